/* File: inc/imm_pkg.sv */
package imm_pkg;

    localparam int CH_W = 8;
    localparam int NCH = 4;
    localparam int NIN = 4;
    localparam int DIM_W = 12;
    localparam int SUM_W = 32;
    localparam int CNT_W = 24;
    localparam int MASK_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int NCH_W = 3;

    // Reset values of the result record and of the sum and count accumulators
    localparam logic [CH_W-1:0] MIN_INIT = 8'hff;
    localparam logic [CH_W-1:0] MAX_INIT = 8'h00;
    localparam logic [SUM_W-1:0] SUM_INIT = 32'h0000_0000;
    localparam logic [CNT_W-1:0] CNT_INIT = 24'h00_0000;

    typedef enum logic [2:0] {
        max_images_mode = 3'b000,
        scalar_maximum_mode = 3'b001,
        min_images_mode = 3'b010,
        scalar_minimum_mode = 3'b011,
        mean_mode = 3'b100,
        extremum_search_mode = 3'b101,
        merge_mode = 3'b110
    } op_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_DIV = 2'b10
    } run_state_t;

    typedef logic [NCH-1:0][CH_W-1:0] pix_t;

    typedef struct packed {
        op_mode_t mode;
        logic [NCH_W-1:0] nch;
        logic [NCH_W-1:0] merge_n;
        logic use_mask;
        logic [CH_W-1:0] scalar;
        logic [DIM_W-1:0] rows;
        logic [DIM_W-1:0] cols;
    } cfg_t;

    typedef struct packed {
        logic [CH_W-1:0] mean;
        logic [CH_W-1:0] min_val;
        logic [CH_W-1:0] max_val;
        logic [DIM_W-1:0] min_row;
        logic [DIM_W-1:0] min_col;
        logic [DIM_W-1:0] max_row;
        logic [DIM_W-1:0] max_col;
        logic found;
    } res_t;

endpackage

/* File: logic/img_fifo.sv */
`timescale 1ns/1ps
module img_fifo
    import imm_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_mclk, // Clock
    input wire logic i_reset, // Sync reset, high
    input wire logic i_ce, // Clock enable
    input wire logic i_in_valid, // Write valid
    output logic o_in_ready, // Room in store
    input wire logic [WIDTH-1:0] i_in_data, // Write data
    output logic o_out_valid, // Head word valid
    input wire logic i_out_ready, // Reader takes head
    output logic [WIDTH-1:0] o_out_data // Head word
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0] count_reg;
    logic [PW:0] count_next;

    wire push = i_in_valid && o_in_ready;
    // Head register refills when empty or being taken, so outputs stay registered
    wire load = (!o_out_valid || i_out_ready) && (count_reg != '0);

    assign count_next = count_reg + (PW+1)'(push) - (PW+1)'(load);

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            o_in_ready <= 1'b0;
            o_out_valid <= 1'b0;
            o_out_data <= '0;
        end else if (i_ce) begin
            if (push) begin
                mem[wr_ptr_reg] <= i_in_data;
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (load) begin
                o_out_data <= mem[rd_ptr_reg];
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
                o_out_valid <= 1'b1;
            end else if (i_out_ready) begin
                o_out_valid <= 1'b0;
            end
            count_reg <= count_next;
            o_in_ready <= count_next < (PW+1)'(DEPTH);
        end
    end
endmodule

/* File: logic/image_minmax_mean_merge.sv */
`timescale 1ns/1ps
// Contract
// - Two-image max gives larger element per channel
// - Scalar max gives larger of element, scalar
// - Two-image min gives smaller element per channel
// - Scalar min gives smaller of element, scalar
// - Every input pixel consumed once, full output
// - Mean returns channel 0 average only
// - Masked mean divides nonzero-mask sum by count
// - Merge puts input k in channel k
// - Merge channel count equals connected inputs
// - Report global min, max and their locations
// - Masked search skips zero-mask positions
// - Min and max share one format
module image_minmax_mean_merge
    import imm_pkg::*;
(
    input wire logic i_mclk, // 40 MHz clock
    input wire logic i_reset, // Sync reset, high
    input wire logic i_ce, // Clock enable
    input wire logic i_start, // Start pulse, idle only
    input wire cfg_t i_cfg, // Operation setup
    input wire logic [NIN-1:0] i_in_valid, // Input stream valids
    input wire pix_t [NIN-1:0] i_in_data, // 0 is first_image_in
    output logic [NIN-1:0] o_in_ready, // Input stream readies
    input wire logic i_mask_valid, // Mask stream valid
    input wire logic [MASK_W-1:0] i_mask_data, // Mask element
    output logic o_mask_ready, // Mask stream ready
    output logic o_out_valid, // Output pixel valid
    output pix_t o_out_data, // Output pixel
    input wire logic i_out_ready, // Downstream ready
    output logic o_busy, // Operation running
    output logic o_res_valid, // Scalar results valid
    output res_t o_res // Scalar results
);

    // Ties pick either operand; equal values make the choice invisible
    function automatic logic [CH_W-1:0] larger_of(
        input logic [CH_W-1:0] a,
        input logic [CH_W-1:0] b
    );
        return (a > b) ? a : b;
    endfunction

    function automatic logic [CH_W-1:0] smaller_of(
        input logic [CH_W-1:0] a,
        input logic [CH_W-1:0] b
    );
        return (a < b) ? a : b;
    endfunction

    function automatic logic [CH_W-1:0] elem_op(
        input op_mode_t mode,
        input logic [CH_W-1:0] a,
        input logic [CH_W-1:0] b,
        input logic [CH_W-1:0] s
    );
        logic [CH_W-1:0] r;
        r = '0;
        case (mode)
            max_images_mode: r = larger_of(a, b);
            scalar_maximum_mode: r = larger_of(a, s);
            min_images_mode: r = smaller_of(a, b);
            scalar_minimum_mode: r = smaller_of(a, s);
            default: r = a;
        endcase
        return r;
    endfunction

    function automatic logic needs_mask(input cfg_t c);
        return c.use_mask && (c.mode == mean_mode || c.mode == extremum_search_mode);
    endfunction

    // Empty record: extremes start at the far ends so any counted pixel replaces them
    function automatic res_t fresh_result();
        res_t r;
        r = '0;
        r.min_val = MIN_INIT;
        r.max_val = MAX_INIT;
        return r;
    endfunction

    cfg_t cfg_reg;
    cfg_t cfg_next;
    run_state_t state_reg;
    run_state_t state_next;
    logic [NIN-1:0] held_reg;
    logic [NIN-1:0] held_next;
    logic [NIN-1:0] need;
    pix_t [NIN-1:0] hold_data_reg;
    logic mask_held_reg;
    logic mask_held_next;
    logic [MASK_W-1:0] mask_data_reg;
    logic [DIM_W-1:0] row_reg;
    logic [DIM_W-1:0] col_reg;
    logic [SUM_W-1:0] sum_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [SUM_W-1:0] quo_reg;
    logic [CNT_W:0] rem_reg;
    logic [$clog2(SUM_W+1)-1:0] div_cnt_reg;
    res_t res_reg;
    res_t res_upd;
    pix_t out_pix;
    logic fifo_in_ready;

    wire start_ok = (state_reg == ST_IDLE) && i_start;
    // Readiness on the start edge must already follow the setup being loaded
    assign cfg_next = start_ok ? i_cfg : cfg_reg;
    wire mask_need = needs_mask(cfg_next);
    wire image_mode = (cfg_reg.mode != mean_mode) && (cfg_reg.mode != extremum_search_mode);
    wire two_image = (cfg_reg.mode == max_images_mode) || (cfg_reg.mode == min_images_mode);
    wire all_held = ((held_reg & need) == need) && (mask_held_reg || !mask_need);
    // Image modes stall on the FIFO so downstream back-pressure reaches the inputs
    wire fire = (state_reg == ST_RUN) && all_held && (!image_mode || fifo_in_ready);
    wire last_col = (col_reg == cfg_reg.cols - 1'b1);
    wire last_row = (row_reg == cfg_reg.rows - 1'b1);
    wire last_pix = last_col && last_row;
    wire mask_on = !cfg_reg.use_mask || (mask_data_reg != '0);
    wire [CH_W-1:0] v0 = hold_data_reg[0][0];
    wire [NIN-1:0] take = i_in_valid & o_in_ready;
    wire mask_take = i_mask_valid && o_mask_ready;
    wire [CNT_W:0] rem_shift = {rem_reg[CNT_W-1:0], quo_reg[SUM_W-1]};
    wire rem_ge = rem_shift >= {1'b0, cnt_reg};
    // Next quotient word; on the last step its low byte is the mean
    wire [SUM_W-1:0] quo_shift = {quo_reg[SUM_W-2:0], rem_ge};
    wire div_last = (div_cnt_reg == ($clog2(SUM_W+1))'(SUM_W - 1));

    // Streams a pixel needs; merge takes one stream per connected input
    always_comb begin
        need = '0;
        case (cfg_next.mode)
            max_images_mode,
            min_images_mode: need = 4'h3;
            merge_mode: begin
                for (int k = 0; k < NIN; k++) begin
                    need[k] = (k < int'(cfg_next.merge_n));
                end
            end
            default: need = 4'h1;
        endcase
    end

    always_comb begin
        out_pix = '0;
        for (int c = 0; c < NCH; c++) begin
            if (cfg_reg.mode == merge_mode) begin
                if (c < int'(cfg_reg.merge_n)) begin
                    out_pix[c] = hold_data_reg[c][0];
                end
            end else if (c < int'(cfg_reg.nch)) begin
                out_pix[c] = elem_op(cfg_reg.mode, hold_data_reg[0][c],
                    two_image ? hold_data_reg[1][c] : '0, cfg_reg.scalar);
            end
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_start) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                if (fire && last_pix) begin
                    // Mean needs the divide; other modes end on the last pixel
                    state_next = (cfg_reg.mode == mean_mode) ? ST_DIV : ST_IDLE;
                end
            end
            ST_DIV: begin
                if (div_last) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Holding registers let each stream hand over its pixel independently
    assign held_next = (fire ? '0 : held_reg) | take;
    assign mask_held_next = (fire ? 1'b0 : mask_held_reg) | mask_take;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            cfg_reg <= '0;
            held_reg <= '0;
            mask_held_reg <= 1'b0;
            o_in_ready <= '0;
            o_mask_ready <= 1'b0;
            o_busy <= 1'b0;
        end else if (i_ce) begin
            state_reg <= state_next;
            if (start_ok) begin
                cfg_reg <= i_cfg;
            end
            held_reg <= held_next;
            mask_held_reg <= mask_held_next;
            // Ready drops once a pixel is held, so none is taken twice
            o_in_ready <= (state_next == ST_RUN) ? (need & ~held_next) : '0;
            o_mask_ready <= (state_next == ST_RUN) && mask_need && !mask_held_next;
            o_busy <= (state_next != ST_IDLE);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            hold_data_reg <= '0;
            mask_data_reg <= '0;
        end else if (i_ce) begin
            for (int k = 0; k < NIN; k++) begin
                if (take[k]) begin
                    hold_data_reg[k] <= i_in_data[k];
                end
            end
            if (mask_take) begin
                mask_data_reg <= i_mask_data;
            end
        end
    end

    // Position of the pixel being processed, raster order
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            row_reg <= '0;
            col_reg <= '0;
        end else if (i_ce) begin
            if (start_ok) begin
                row_reg <= '0;
                col_reg <= '0;
            end else if (fire) begin
                col_reg <= last_col ? '0 : col_reg + 1'b1;
                if (last_col) begin
                    row_reg <= row_reg + 1'b1;
                end
            end
        end
    end

    // Record after this cycle's pixel; the output copy takes it so the last pixel counts
    always_comb begin
        res_upd = res_reg;
        if (fire && mask_on) begin
            res_upd.found = 1'b1;
            // Strict compares keep the first raster hit
            if (!res_reg.found || v0 < res_reg.min_val) begin
                res_upd.min_val = v0;
                res_upd.min_row = row_reg;
                res_upd.min_col = col_reg;
            end
            if (!res_reg.found || v0 > res_reg.max_val) begin
                res_upd.max_val = v0;
                res_upd.max_row = row_reg;
                res_upd.max_col = col_reg;
            end
        end
        if (state_reg == ST_DIV && div_last) begin
            // Mean of 8-bit elements always fits the low byte
            res_upd.mean = quo_shift[CH_W-1:0];
        end
    end

    // Channel 0 accumulation and extremum search
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            sum_reg <= SUM_INIT;
            cnt_reg <= CNT_INIT;
            res_reg <= fresh_result();
        end else if (i_ce) begin
            if (start_ok) begin
                sum_reg <= SUM_INIT;
                cnt_reg <= CNT_INIT;
                res_reg <= fresh_result();
            end else begin
                res_reg <= res_upd;
                if (fire && mask_on) begin
                    sum_reg <= sum_reg + SUM_W'(v0);
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
        end
    end

    // Restoring divider, one quotient bit a cycle; a zero count gives all ones
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            quo_reg <= '0;
            rem_reg <= '0;
            div_cnt_reg <= '0;
        end else if (i_ce) begin
            if (state_reg == ST_RUN && state_next == ST_DIV) begin
                quo_reg <= sum_reg + SUM_W'(mask_on ? v0 : 8'h00);
                rem_reg <= '0;
                div_cnt_reg <= '0;
            end else if (state_reg == ST_DIV) begin
                rem_reg <= rem_ge ? rem_shift - {1'b0, cnt_reg} : rem_shift;
                quo_reg <= quo_shift;
                div_cnt_reg <= div_cnt_reg + 1'b1;
            end
        end
    end

    // Results are published only after the last pixel has been taken
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_res_valid <= 1'b0;
            o_res <= '0;
        end else if (i_ce) begin
            if (start_ok) begin
                o_res_valid <= 1'b0;
            end else if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
                o_res_valid <= 1'b1;
                o_res <= res_upd;
            end
        end
    end

    // Image results leave through the FIFO; its space gates each pixel, so a
    // stalled sink backs up into the input readies.
    img_fifo #(
        .WIDTH($bits(pix_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_out_fifo (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_in_valid(fire && image_mode),
        .o_in_ready(fifo_in_ready),
        .i_in_data(out_pix),
        .o_out_valid(o_out_valid),
        .i_out_ready(i_out_ready),
        .o_out_data(o_out_data)
    );

endmodule

/* File: verif/imm_sva.sv */
`timescale 1ns/1ps
module imm_sva
    import imm_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic [NIN-1:0] i_in_valid,
    input wire logic [NIN-1:0] o_in_ready,
    input wire logic o_mask_ready,
    input wire logic o_out_valid,
    input wire pix_t o_out_data,
    input wire logic i_out_ready,
    input wire logic o_busy,
    input wire logic o_res_valid,
    input wire res_t o_res
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    property p_start_busy;
        i_start && !o_busy && i_ce |=> o_busy;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken");
    property p_out_hold;
        o_out_valid && !i_out_ready && i_ce |=> o_out_valid && $stable(o_out_data);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output pixel dropped");
    property p_beat_once;
        o_in_ready[0] && i_in_valid[0] && i_ce |=> !o_in_ready[0];
    endproperty
    a_beat_once: assert property (p_beat_once) else $error("ready held after beat");
    property p_idle_quiet;
        !o_busy |-> o_in_ready == '0 && !o_mask_ready;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("ready while idle");
    property p_res_late;
        $rose(o_res_valid) |-> $past(o_busy) && !o_busy;
    endproperty
    a_res_late: assert property (p_res_late) else $error("result before end");
    property p_busy_excl;
        o_busy |-> !o_res_valid;
    endproperty
    a_busy_excl: assert property (p_busy_excl) else $error("result valid while busy");
    property p_res_hold;
        o_res_valid && !i_start |=> o_res_valid && $stable(o_res);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result not held");
    property p_order;
        o_res_valid && o_res.found |-> o_res.min_val <= o_res.max_val;
    endproperty
    a_order: assert property (p_order) else $error("minimum above maximum");
    c_res: cover property ($rose(o_res_valid));
    c_stall: cover property (o_out_valid && !i_out_ready);
    c_found: cover property (o_res_valid && o_res.found);
endmodule

bind image_minmax_mean_merge imm_sva u_sva (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_ce(i_ce), .i_start(i_start), .i_in_valid(i_in_valid), .o_in_ready(o_in_ready),
    .o_mask_ready(o_mask_ready), .o_out_valid(o_out_valid), .o_out_data(o_out_data),
    .i_out_ready(i_out_ready), .o_busy(o_busy), .o_res_valid(o_res_valid), .o_res(o_res));

/* File: verif/pix_sink.sv */
`timescale 1ns/1ps
module pix_sink
    import imm_pkg::*;
(
    input wire logic i_mclk, // Clock
    input wire logic i_stall, // Hold ready low
    input wire logic i_slow, // Ready every other cycle
    input wire logic i_valid, // Pixel valid
    input wire pix_t i_data, // Pixel
    output logic o_ready // Taking pixels
);
    pix_t got[$];
    logic phase = 1'b0;
    initial o_ready = 1'b0;
    // Slow mode makes the FIFO head sit through gaps
    always @(posedge i_mclk) begin
        if (i_valid && o_ready) begin
            got.push_back(i_data);
        end
        phase <= ~phase;
        o_ready <= !i_stall && (phase || !i_slow);
    end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench
    import imm_pkg::*;
;
    logic i_mclk = 1'b0, i_reset = 1'b1, i_ce = 1'b1, i_start = 1'b0;
    logic stall = 1'b0, slow = 1'b0, mv = 1'b0, m_rdy, ov, ordy, busy, rv;
    logic [NIN-1:0] iv = '0, in_rdy;
    logic [MASK_W-1:0] md = '0;
    cfg_t cfg = '0;
    pix_t [NIN-1:0] id = '0;
    pix_t od;
    res_t res;
    pix_t q[NIN][$];
    pix_t exq[$];
    logic [MASK_W-1:0] mq[$];
    int miscompares = 0, num_checks = 0;

    image_minmax_mean_merge u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
        .i_start(i_start), .i_cfg(cfg), .i_in_valid(iv), .i_in_data(id), .o_in_ready(in_rdy),
        .i_mask_valid(mv), .i_mask_data(md), .o_mask_ready(m_rdy), .o_out_valid(ov),
        .o_out_data(od), .i_out_ready(ordy), .o_busy(busy), .o_res_valid(rv), .o_res(res));
    pix_sink u_sink (.i_mclk(i_mclk), .i_stall(stall), .i_slow(slow), .i_valid(ov),
        .i_data(od), .o_ready(ordy));

    initial forever #12.5 i_mclk = ~i_mclk;

    // Idle lines toggle so a stale value is never mistaken for a beat
    always @(posedge i_mclk) begin
        for (int k = 0; k < NIN; k++) begin
            if (iv[k] && in_rdy[k] && i_ce) void'(q[k].pop_front());
            iv[k] <= q[k].size() != 0;
            id[k] <= q[k].size() != 0 ? q[k][0] : ~id[k];
        end
        if (mv && m_rdy && i_ce) void'(mq.pop_front());
        mv <= mq.size() != 0;
        md <= mq.size() != 0 ? mq[0] : ~md;
    end

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_pix(string n, pix_t e, pix_t g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_val(string n, logic [DIM_W-1:0] e, logic [DIM_W-1:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic run_op(input cfg_t c);
        int n;
        n = 0;
        u_sink.got.delete();
        @(posedge i_mclk);
        cfg <= c;
        i_start <= 1'b1;
        @(posedge i_mclk);
        i_start <= 1'b0;
        @(posedge i_mclk);
        do begin
            @(negedge i_mclk);
            n++;
        end while ((rv !== 1'b1 || u_sink.got.size() < exq.size()) && n < 3000);
        if (n >= 3000) begin
            miscompares++;
            $display("CHECK FAILED done exp 1 got 0");
        end
    endtask

    task automatic check_out();
        chk_val("count", 12'(exq.size()), 12'(u_sink.got.size()));
        foreach (exq[i]) chk_pix("pixel", exq[i], u_sink.got[i]);
        exq.delete();
    endtask

    task automatic t_pixel();
        op_mode_t ms[4] = '{max_images_mode, min_images_mode, scalar_maximum_mode,
            scalar_minimum_mode};
        pix_t a, b, e;
        logic [CH_W-1:0] o;
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 12; i++) begin
                for (int c = 0; c < NCH; c++) begin
                    a[c] = 8'(i * 29 + c * 70);
                    b[c] = 8'(8'h90 - i * 13 + c);
                    o = (m < 2) ? b[c] : 8'h60;
                    e[c] = ((a[c] > o) == (m % 2 == 0)) ? a[c] : o;
                end
                q[0].push_back(a);
                if (m < 2) q[1].push_back(b);
                exq.push_back(e);
            end
            // Twelve pixels overrun the FIFO while the sink is stopped; a
            // clock-enable gap in that run must freeze every stream
            stall <= (m == 0);
            slow <= (m == 1);
            fork
                begin
                    repeat (12) @(posedge i_mclk);
                    i_ce <= !stall;
                    repeat (6) @(posedge i_mclk);
                    i_ce <= 1'b1;
                    repeat (42) @(posedge i_mclk);
                    stall <= 1'b0;
                end
            join_none
            run_op('{ms[m], 3'h4, 3'h2, 1'b0, 8'h60, 12'h3, 12'h4});
            check_out();
        end
    endtask

    task automatic t_mean();
        pix_t p;
        int s, n;
        for (int k = 0; k < 2; k++) begin
            s = 0;
            n = 0;
            for (int i = 0; i < 6; i++) begin
                p = '0;
                p[0] = 8'(i * 41 + 7);
                p[1] = 8'hff;
                q[0].push_back(p);
                if (k) mq.push_back(8'(i % 3));
                if (!k || i % 3 != 0) begin
                    s += p[0];
                    n++;
                end
            end
            run_op('{mean_mode, 3'h2, 3'h2, 1'(k), 8'h00, 12'h2, 12'h3});
            chk_val("mean", 12'(s / n), 12'(res.mean));
        end
    endtask

    task automatic t_ext();
        logic [CH_W-1:0] v[9] = '{8'h40, 8'h10, 8'hc0, 8'h10, 8'hc0, 8'h05, 8'h55, 8'hc0,
            8'hf0};
        logic [DIM_W-1:0] ex[2][6] = '{'{12'h5, 12'hf0, 12'h1, 12'h2, 12'h2, 12'h2},
            '{12'h10, 12'hc0, 12'h0, 12'h1, 12'h0, 12'h2}};
        logic [DIM_W-1:0] g[6];
        pix_t p;
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 9; i++) begin
                p = '0;
                p[0] = v[i];
                q[0].push_back(p);
                if (k) mq.push_back((i == 5 || i == 8) ? 8'h00 : 8'h81);
            end
            run_op('{extremum_search_mode, 3'h1, 3'h2, 1'(k), 8'h00, 12'h3, 12'h3});
            g = '{12'(res.min_val), 12'(res.max_val), res.min_row, res.min_col,
                res.max_row, res.max_col};
            for (int j = 0; j < 6; j++) chk_val("extremum", ex[k][j], g[j]);
            chk_val("found", 12'h1, 12'(res.found));
        end
    endtask

    task automatic t_merge();
        pix_t p, e;
        for (int n = 2; n <= 4; n++) begin
            for (int i = 0; i < 4; i++) begin
                e = '0;
                for (int k = 0; k < n; k++) begin
                    p = {NCH{8'h5a}};
                    p[0] = 8'(k * 64 + i + n);
                    q[k].push_back(p);
                    e[k] = p[0];
                end
                exq.push_back(e);
            end
            run_op('{merge_mode, 3'(n), 3'(n), 1'b0, 8'h00, 12'h2, 12'h2});
            check_out();
        end
    endtask

    initial begin
        repeat (6) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(negedge i_mclk);
        t_pixel();
        t_mean();
        t_ext();
        t_merge();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        miscompares++;
        $display("CHECK FAILED watchdog exp finish got timeout");
        print_verdict();
    end
endmodule
